// file: rtl/flow_pkg.sv
package flow_pkg;
    // ==========================================================
    // operation codes presented by the fetch/decode path
    localparam int OP_W = 5;
    localparam logic [4:0] OP_NONE = 5'h00;
    localparam logic [4:0] OP_ZCALL = 5'h01;
    localparam logic [4:0] OP_SUB_EXIT = 5'h02;
    localparam logic [4:0] OP_INT_EXIT = 5'h03;
    localparam logic [4:0] OP_CMP_SKIP_EQ = 5'h04;
    localparam logic [4:0] OP_CMP = 5'h05;
    localparam logic [4:0] OP_CMP_CARRY = 5'h06;
    localparam logic [4:0] OP_CMP_IMM = 5'h07;
    localparam logic [4:0] OP_SKIP_RBIT_CLR = 5'h08;
    localparam logic [4:0] OP_SKIP_RBIT_SET = 5'h09;
    localparam logic [4:0] OP_SKIP_IO_CLR = 5'h0A;
    localparam logic [4:0] OP_SKIP_IO_SET = 5'h0B;
    localparam logic [4:0] OP_BR_BIT_ONE = 5'h0C;
    localparam logic [4:0] OP_BR_BIT_ZERO = 5'h0D;
    localparam logic [4:0] OP_BR_EQ = 5'h0E;
    localparam logic [4:0] OP_BR_NE = 5'h0F;
    localparam logic [4:0] OP_BR_C_ONE = 5'h10;
    localparam logic [4:0] OP_BR_C_ZERO = 5'h11;
    localparam logic [4:0] OP_BR_AT_LEAST = 5'h12;
    localparam logic [4:0] OP_BR_BELOW = 5'h13;
    localparam logic [4:0] OP_BR_NEG = 5'h14;
    localparam logic [4:0] OP_BR_NONNEG = 5'h15;
    // ==========================================================
    // flag_register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_I = 7;
    // ==========================================================
    // cycle counts
    localparam logic [1:0] CYC_ZCALL = 2'h3;
    localparam logic [1:0] CYC_SUB_EXIT = 2'h3;
    localparam logic [1:0] CYC_BR_TAKEN = 2'h1;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h1;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h2;
    // ==========================================================
    // register map and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EVENTS = 8'h08;
    localparam int CTRL_EN = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_READY = 1;
    localparam int ST_OP = 8;
    localparam int ST_FLAGS = 16;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/branch_skip_compare_decode.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module branch_skip_compare_decode
    import flow_pkg::*;
#(
    parameter int PC_W = 16
)
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic INSTR_VALID,
    output logic INSTR_READY,
    input wire logic [4:0] OPCODE,
    input wire logic [2:0] BIT_SEL,
    input wire logic [6:0] OFFSET,
    input wire logic [7:0] IMM,
    input wire logic NEXT_IS_TWO_WORD,
    input wire logic [7:0] RD_VAL,
    input wire logic [7:0] RR_VAL,
    input wire logic IO_BIT,
    input wire logic [7:0] FLAGS_IN,
    input wire logic [PC_W-1:0] Z_PTR,
    input wire logic [PC_W-1:0] STACK_PC,
    output logic [PC_W-1:0] PC,
    output logic [PC_W-1:0] RET_ADDR,
    output logic STACK_PUSH,
    output logic STACK_POP,
    output logic [7:0] FLAGS_OUT,
    output logic FLAGS_WE,
    output logic FLUSH,
    output logic BUSY,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [7:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [7:0] ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP
);
    // ==========================================================
    // parameter check
    if (PC_W < 8 || PC_W > 16)
    begin : g_bad_width
        $error("PC_W must lie between 8 and 16");
    end

    // ==========================================================
    // reset release
    logic [1:0] sync_r;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            sync_r <= 2'h0;
        else
            sync_r <= {sync_r[0], 1'b1};
    end
    assign rst_n = sync_r[1];

    // ==========================================================
    // execution state
    logic [PC_W-1:0] pc_r, pc_nxt, ret_r, ret_nxt, off_ext;
    logic [7:0] flags_r, flags_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [4:0] last_op_r, last_op_nxt;
    logic we_r, we_nxt, push_r, push_nxt, pop_r, pop_nxt;
    logic flush_r, flush_nxt, busy_r, busy_nxt, ready_r, ready_nxt;
    logic take, cond, jump, ctrl_en_r;

    assign take = INSTR_VALID && ready_r;
    assign off_ext = {{(PC_W-7){OFFSET[6]}}, OFFSET};

    function automatic logic [7:0] cmp_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin,
        input logic [7:0] f
    );
        logic [7:0] r;
        logic [7:0] o;
        r = a - b - {7'h00, cin};
        o = f;
        o[FLAG_Z] = (r == 8'h00);
        o[FLAG_N] = r[7];
        o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        o[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        o[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        return o;
    endfunction

    // condition of skips and branches
    always_comb
    begin
        cond = 1'b0;
        unique case (OPCODE)
            OP_CMP_SKIP_EQ: cond = (RD_VAL == RR_VAL);
            OP_SKIP_RBIT_CLR: cond = !RR_VAL[BIT_SEL];
            OP_SKIP_RBIT_SET: cond = RR_VAL[BIT_SEL];
            OP_SKIP_IO_CLR: cond = !IO_BIT;
            OP_SKIP_IO_SET: cond = IO_BIT;
            OP_BR_BIT_ONE: cond = FLAGS_IN[BIT_SEL];
            OP_BR_BIT_ZERO: cond = !FLAGS_IN[BIT_SEL];
            OP_BR_EQ: cond = FLAGS_IN[FLAG_Z];
            OP_BR_NE: cond = !FLAGS_IN[FLAG_Z];
            OP_BR_C_ONE: cond = FLAGS_IN[FLAG_C];
            OP_BR_C_ZERO: cond = !FLAGS_IN[FLAG_C];
            OP_BR_AT_LEAST: cond = !FLAGS_IN[FLAG_C];
            OP_BR_BELOW: cond = FLAGS_IN[FLAG_C];
            OP_BR_NEG: cond = FLAGS_IN[FLAG_N];
            OP_BR_NONNEG: cond = !FLAGS_IN[FLAG_N];
            default: cond = 1'b0;
        endcase
    end

    always_comb
    begin
        pc_nxt = pc_r;
        ret_nxt = ret_r;
        flags_nxt = flags_r;
        last_op_nxt = last_op_r;
        we_nxt = 1'b0;
        push_nxt = 1'b0;
        pop_nxt = 1'b0;
        flush_nxt = 1'b0;
        jump = 1'b0;
        cnt_nxt = (cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0;
        if (take)
        begin
            last_op_nxt = OPCODE;
            pc_nxt = pc_r + 1'b1;
            unique case (OPCODE)
                OP_ZCALL:
                begin
                    ret_nxt = pc_r + 1'b1;
                    push_nxt = 1'b1;
                    pc_nxt = Z_PTR;
                    cnt_nxt = CYC_ZCALL - 2'h1;
                    flush_nxt = 1'b1;
                end
                OP_SUB_EXIT, OP_INT_EXIT:
                begin
                    pop_nxt = 1'b1;
                    pc_nxt = STACK_PC;
                    cnt_nxt = CYC_SUB_EXIT;
                    flush_nxt = 1'b1;
                    if (OPCODE == OP_INT_EXIT)
                    begin
                        flags_nxt = FLAGS_IN;
                        flags_nxt[FLAG_I] = 1'b1;
                        we_nxt = 1'b1;
                    end
                end
                OP_CMP:
                begin
                    flags_nxt = cmp_flags(RD_VAL, RR_VAL, 1'b0,
                        FLAGS_IN);
                    we_nxt = 1'b1;
                end
                OP_CMP_CARRY:
                begin
                    flags_nxt = cmp_flags(RD_VAL, RR_VAL,
                        FLAGS_IN[FLAG_C], FLAGS_IN);
                    we_nxt = 1'b1;
                end
                OP_CMP_IMM:
                begin
                    flags_nxt = cmp_flags(RD_VAL, IMM, 1'b0, FLAGS_IN);
                    we_nxt = 1'b1;
                end
                OP_CMP_SKIP_EQ, OP_SKIP_RBIT_CLR, OP_SKIP_RBIT_SET,
                OP_SKIP_IO_CLR, OP_SKIP_IO_SET:
                begin
                    if (cond)
                    begin
                        jump = 1'b1;
                        flush_nxt = 1'b1;
                        pc_nxt = pc_r
                            + (NEXT_IS_TWO_WORD ? 2'h3 : 2'h2);
                        cnt_nxt = NEXT_IS_TWO_WORD ? CYC_SKIP_TWO
                            : CYC_SKIP_ONE;
                    end
                end
                OP_BR_BIT_ONE, OP_BR_BIT_ZERO, OP_BR_EQ, OP_BR_NE,
                OP_BR_C_ONE, OP_BR_C_ZERO, OP_BR_AT_LEAST, OP_BR_BELOW,
                OP_BR_NEG, OP_BR_NONNEG:
                begin
                    if (cond)
                    begin
                        jump = 1'b1;
                        flush_nxt = 1'b1;
                        pc_nxt = pc_r + off_ext + 1'b1;
                        cnt_nxt = CYC_BR_TAKEN;
                    end
                end
                default:
                begin
                    pc_nxt = pc_r + 1'b1;
                end
            endcase
        end
        busy_nxt = (cnt_nxt != 2'h0);
        ready_nxt = ctrl_en_r && (cnt_nxt == 2'h0);
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_r <= PC_RESET[PC_W-1:0];
            ret_r <= PC_RESET[PC_W-1:0];
            flags_r <= 8'h00;
            cnt_r <= 2'h0;
            last_op_r <= OP_NONE;
            we_r <= 1'b0;
            push_r <= 1'b0;
            pop_r <= 1'b0;
            flush_r <= 1'b0;
            busy_r <= 1'b0;
            ready_r <= 1'b0;
        end
        else
        begin
            pc_r <= pc_nxt;
            ret_r <= ret_nxt;
            flags_r <= flags_nxt;
            cnt_r <= cnt_nxt;
            last_op_r <= last_op_nxt;
            we_r <= we_nxt;
            push_r <= push_nxt;
            pop_r <= pop_nxt;
            flush_r <= flush_nxt;
            busy_r <= busy_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign PC = pc_r;
    assign RET_ADDR = ret_r;
    assign FLAGS_OUT = flags_r;
    assign FLAGS_WE = we_r;
    assign STACK_PUSH = push_r;
    assign STACK_POP = pop_r;
    assign FLUSH = flush_r;
    assign BUSY = busy_r;
    assign INSTR_READY = ready_r;

    // ==========================================================
    // register slave
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt, ctrl_en_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [15:0] events_r, events_nxt;

    always_comb
    begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !BREADY;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !RREADY;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        ctrl_en_nxt = ctrl_en_r;
        events_nxt = events_r;
        if (AWVALID && awready_r)
        begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = AWADDR;
        end
        if (WVALID && wready_r)
        begin
            w_have_nxt = 1'b1;
            wdata_nxt = WDATA;
            wstrb_nxt = WSTRB;
        end
        if (aw_have_r && w_have_r && !bvalid_r)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            unique case (awaddr_r)
                REG_CTRL:
                    if (wstrb_r[0])
                        ctrl_en_nxt = wdata_r[CTRL_EN];
                REG_EVENTS:
                    if (wstrb_r[0])
                        events_nxt = 16'h0000;
                REG_STATUS: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end
        // an event in the same cycle as a clear is counted after it
        if (jump)
            events_nxt = events_nxt + 16'h0001;
        if (ARVALID && arready_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case (ARADDR)
                REG_CTRL: rdata_nxt[CTRL_EN] = ctrl_en_r;
                REG_STATUS:
                begin
                    rdata_nxt[ST_BUSY] = busy_r;
                    rdata_nxt[ST_READY] = ready_r;
                    rdata_nxt[ST_OP +: 5] = last_op_r;
                    rdata_nxt[ST_FLAGS +: 8] = flags_r;
                end
                REG_EVENTS: rdata_nxt[15:0] = events_r;
                default: rresp_nxt = RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_have_nxt;
        wready_nxt = !w_have_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
            ctrl_en_r <= CTRL_EN_RESET;
            events_r <= 16'h0000;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            ctrl_en_r <= ctrl_en_nxt;
            events_r <= events_nxt;
        end
    end

    assign AWREADY = awready_r;
    assign WREADY = wready_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = arready_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!rst_n);

    sequence busy_two;
        BUSY [*2] ##1 !BUSY;
    endsequence

    sequence busy_three;
        BUSY [*3] ##1 !BUSY;
    endsequence

    zcall_target_a: assert property (
        take && OPCODE == OP_ZCALL |=> PC == $past(Z_PTR) && !FLAGS_WE
            ##0 busy_two)
        else $error("indirect call target or timing wrong");
    sub_exit_a: assert property (
        take && OPCODE == OP_SUB_EXIT |=> PC == $past(STACK_PC)
            && !FLAGS_WE ##0 busy_three)
        else $error("subroutine return wrong");
    int_exit_a: assert property (
        take && OPCODE == OP_INT_EXIT |=> FLAGS_WE && FLAGS_OUT[FLAG_I]
            ##0 busy_three)
        else $error("interrupt exit wrong");
    cmp_zero_a: assert property (
        take && OPCODE == OP_CMP |=> FLAGS_WE && !BUSY
            && FLAGS_OUT[FLAG_Z] == ($past(RD_VAL) == $past(RR_VAL)))
        else $error("compare zero flag wrong");
    cmp_carry_a: assert property (
        take && OPCODE == OP_CMP_CARRY && RD_VAL == RR_VAL
            && FLAGS_IN[FLAG_C] |=> FLAGS_OUT[FLAG_C] && !FLAGS_OUT[FLAG_Z])
        else $error("compare with carry wrong");
    cmp_imm_a: assert property (
        take && OPCODE == OP_CMP_IMM |=> FLAGS_WE && !BUSY
            && FLAGS_OUT[FLAG_C] == ($past(RD_VAL) < $past(IMM)))
        else $error("immediate compare carry wrong");
    skip_equal_a: assert property (
        take && OPCODE == OP_CMP_SKIP_EQ && RD_VAL == RR_VAL
            && !NEXT_IS_TWO_WORD |=> PC == $past(PC) + 2'h2 && !FLAGS_WE
            ##0 BUSY ##1 !BUSY)
        else $error("equal skip wrong");
    skip_long_a: assert property (
        take && OPCODE == OP_SKIP_RBIT_CLR && !RR_VAL[BIT_SEL]
            && NEXT_IS_TWO_WORD |=> PC == $past(PC) + 2'h3 ##0 busy_two)
        else $error("two word skip wrong");
    no_skip_a: assert property (
        take && OPCODE == OP_SKIP_IO_SET && !IO_BIT
            |=> PC == $past(PC) + 1'b1 && !BUSY && !FLUSH)
        else $error("untaken skip wrong");
    branch_taken_a: assert property (
        take && OPCODE == OP_BR_EQ && FLAGS_IN[FLAG_Z]
            |=> PC == $past(PC) + $past(off_ext) + 1'b1 && FLUSH
            && !FLAGS_WE ##0 BUSY ##1 !BUSY)
        else $error("taken branch wrong");
    branch_fall_a: assert property (
        take && OPCODE == OP_BR_C_ONE && !FLAGS_IN[FLAG_C]
            |=> !BUSY && !FLUSH && PC == $past(PC) + 1'b1)
        else $error("untaken branch wrong");
endmodule

// file: test/tb_branch_skip_compare_decode.sv
`timescale 1ns/1ps
module tb_branch_skip_compare_decode
    import flow_pkg::*;
    ;
    // ==========================================================
    // stimulus and observed signals
    logic CLOCK = 0, RST_N = 0, INSTR_VALID = 0, NEXT_IS_TWO_WORD = 0;
    logic IO_BIT = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic ARVALID = 0, RREADY = 0;
    logic [4:0] OPCODE = 0;
    logic [2:0] BIT_SEL = 0;
    logic [6:0] OFFSET = 0;
    logic [7:0] IMM = 0, RD_VAL = 0, RR_VAL = 0, FLAGS_IN = 0;
    logic [7:0] AWADDR = 0, ARADDR = 0, FLAGS_OUT;
    logic [15:0] Z_PTR = 0, STACK_PC = 0, PC, RET_ADDR;
    logic [31:0] WDATA = 0, RDATA;
    logic INSTR_READY, STACK_PUSH, STACK_POP, FLAGS_WE, FLUSH, BUSY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    int n_fail = 0, checks = 0, ev = 0;
    logic [15:0] pcx = 0;
    logic [7:0] fx, va, vb;
    logic [4:0] op;
    logic [6:0] k;
    logic [2:0] bs;
    logic t, c, tw;
    logic [7:0] av[5] = '{8'h10, 8'h00, 8'h80, 8'h3A, 8'h7F};
    logic [7:0] bv[5] = '{8'h10, 8'h01, 8'h01, 8'h3B, 8'hFF};
    logic [7:0] fp[6] = '{8'h01, 8'h02, 8'h04, 8'hFE, 8'hFD, 8'hFB};
    logic [4:0] so[5] = '{OP_CMP_SKIP_EQ, OP_SKIP_RBIT_CLR,
        OP_SKIP_RBIT_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET};

    always #25 CLOCK = ~CLOCK;

    branch_skip_compare_decode uut (
        .CLOCK(CLOCK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
        .INSTR_READY(INSTR_READY), .OPCODE(OPCODE), .BIT_SEL(BIT_SEL),
        .OFFSET(OFFSET), .IMM(IMM), .NEXT_IS_TWO_WORD(NEXT_IS_TWO_WORD),
        .RD_VAL(RD_VAL), .RR_VAL(RR_VAL), .IO_BIT(IO_BIT),
        .FLAGS_IN(FLAGS_IN), .Z_PTR(Z_PTR), .STACK_PC(STACK_PC), .PC(PC),
        .RET_ADDR(RET_ADDR), .STACK_PUSH(STACK_PUSH), .STACK_POP(STACK_POP),
        .FLAGS_OUT(FLAGS_OUT), .FLAGS_WE(FLAGS_WE), .FLUSH(FLUSH),
        .BUSY(BUSY), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY),
        .WDATA(WDATA), .WSTRB(4'hF), .BVALID(BVALID), .BREADY(BREADY),
        .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY),
        .RDATA(RDATA), .RRESP(RRESP));

    // ==========================================================
    // reference models
    function automatic logic [7:0] cflg(input logic [7:0] a, b,
        input logic ci, input logic [7:0] fi);
        logic [8:0] d;
        logic [7:0] r;
        d = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        r = d[7:0];
        cflg = fi;
        cflg[FLAG_C] = d[8];
        cflg[FLAG_Z] = (r == 8'h00);
        cflg[FLAG_N] = r[7];
        cflg[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        cflg[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    endfunction

    function automatic logic bcond(input logic [4:0] o,
        input logic [7:0] f, input logic [2:0] s);
        case (o)
            OP_BR_BIT_ONE: return f[s];
            OP_BR_BIT_ZERO: return !f[s];
            OP_BR_EQ: return f[FLAG_Z];
            OP_BR_NE: return !f[FLAG_Z];
            OP_BR_C_ONE, OP_BR_BELOW: return f[FLAG_C];
            OP_BR_NEG: return f[FLAG_N];
            OP_BR_NONNEG: return !f[FLAG_N];
            default: return !f[FLAG_C];
        endcase
    endfunction

    // ==========================================================
    // checking and bus tasks
    task test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task tmo(input int n);
        if (n >= 60)
        begin
            n_fail++;
            test_done();
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1;
        WVALID <= 1;
        BREADY <= 1;
        n = 0;
        do
        begin
            @(posedge CLOCK);
            n++;
            if (AWREADY === 1'b1) AWVALID <= 0;
            if (WREADY === 1'b1) WVALID <= 0;
        end
        while (BVALID !== 1'b1 && n < 60);
        tmo(n);
        BREADY <= 0;
        chk("bresp", BRESP, er);
        @(posedge CLOCK);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        ARADDR <= a;
        ARVALID <= 1;
        RREADY <= 1;
        n = 0;
        do
        begin
            @(posedge CLOCK);
            n++;
            if (ARREADY === 1'b1) ARVALID <= 0;
        end
        while (RVALID !== 1'b1 && n < 60);
        tmo(n);
        RREADY <= 0;
        chk("rdata", RDATA, ed);
        chk("rresp", RRESP, er);
        @(posedge CLOCK);
    endtask

    task ins(input logic [4:0] o, input logic [15:0] epc, input int eb,
        input logic efl, input logic ewe, input logic [7:0] ef);
        int n;
        logic [15:0] ra;
        ra = pcx + 16'h0001;
        OPCODE <= o;
        INSTR_VALID <= 1;
        n = 0;
        do
        begin
            @(posedge CLOCK);
            n++;
        end
        while (INSTR_READY !== 1'b1 && n < 60);
        tmo(n);
        INSTR_VALID <= 0;
        #1;
        chk("pc", PC, epc);
        chk("flush", FLUSH, efl);
        chk("flags_we", FLAGS_WE, ewe);
        if (ewe) chk("flags", FLAGS_OUT, ef);
        chk("push", STACK_PUSH, o == OP_ZCALL);
        chk("pop", STACK_POP, o == OP_SUB_EXIT || o == OP_INT_EXIT);
        if (o == OP_ZCALL) chk("ret_addr", RET_ADDR, ra);
        n = 0;
        while (BUSY === 1'b1 && n < 8)
        begin
            @(posedge CLOCK);
            #1;
            n++;
        end
        chk("busy", n, eb);
        pcx = epc;
        @(posedge CLOCK);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge CLOCK);
        RST_N <= 1;
        repeat (3) @(posedge CLOCK);
        chk("pc_rst", PC, PC_RESET);
        rd(REG_CTRL, 32'h1, RESP_OKAY);
        rd(REG_STATUS, 32'h2, RESP_OKAY);
        rd(8'h0C, 32'h0, RESP_SLVERR);
        wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
        ins(OP_NONE, 16'h0001, 0, 0, 0, 0);
        Z_PTR <= 16'h0123;
        ins(OP_ZCALL, 16'h0123, 2, 1, 0, 0);
        STACK_PC <= 16'h0040;
        ins(OP_SUB_EXIT, 16'h0040, 3, 1, 0, 0);
        STACK_PC <= 16'h0050;
        FLAGS_IN <= 8'h03;
        ins(OP_INT_EXIT, 16'h0050, 3, 1, 1, 8'h83);
        FLAGS_IN <= 8'h41;
        for (int i = 0; i < 15; i++)
        begin
            op = OP_CMP + 5'(i % 3);
            va = av[i / 3];
            vb = bv[i / 3];
            RD_VAL <= va;
            RR_VAL <= (op == OP_CMP_IMM) ? ~vb : vb;
            IMM <= vb;
            fx = cflg(va, vb, op == OP_CMP_CARRY, 8'h41);
            ins(op, pcx + 16'h0001, 0, 0, 1, fx);
        end
        rd(REG_STATUS, {8'h00, fx, 3'h0, OP_CMP_IMM, 8'h02}, RESP_OKAY);
        for (int i = 0; i < 60; i++)
        begin
            op = OP_BR_BIT_ONE + 5'(i / 6);
            bs = 3'((i + 1) % 8);
            k = i[0] ? 7'h7C : 7'h05;
            FLAGS_IN <= fp[i % 6];
            BIT_SEL <= bs;
            OFFSET <= k;
            t = bcond(op, fp[i % 6], bs);
            ev += t;
            ins(op, t ? pcx + {{9{k[6]}}, k} + 16'h0001 : pcx + 16'h0001,
                t, t, 0, 0);
        end
        RD_VAL <= 8'h5A;
        BIT_SEL <= 3'h3;
        for (int i = 0; i < 20; i++)
        begin
            op = so[i / 4];
            c = i[0];
            tw = i[1];
            RR_VAL <= c ? 8'h5A : 8'hA5;
            IO_BIT <= c;
            NEXT_IS_TWO_WORD <= tw;
            t = (op == OP_SKIP_RBIT_CLR || op == OP_SKIP_IO_CLR) ? !c : c;
            ev += t;
            ins(op, pcx + (t ? (tw ? 16'h0003 : 16'h0002) : 16'h0001),
                t ? 1 + tw : 0, t, 0, 0);
        end
        rd(REG_EVENTS, ev, RESP_OKAY);
        wr(REG_EVENTS, 32'h0, RESP_OKAY);
        rd(REG_EVENTS, 32'h0, RESP_OKAY);
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        OPCODE <= OP_NONE;
        INSTR_VALID <= 1;
        repeat (3) @(posedge CLOCK);
        INSTR_VALID <= 0;
        #1;
        chk("ready_off", INSTR_READY, 0);
        chk("pc_held", PC, pcx);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        ins(OP_NONE, pcx + 16'h0001, 0, 0, 0, 0);
        RST_N <= 0;
        @(posedge CLOCK);
        #1;
        chk("pc_rst2", PC, PC_RESET);
        @(posedge CLOCK);
        RST_N <= 1;
        repeat (3) @(posedge CLOCK);
        pcx = PC_RESET;
        ins(OP_NONE, 16'h0001, 0, 0, 0, 0);
        test_done();
    end
endmodule
